// ### core/cci_top.sv
// control channel i2c settings, supervision and address remap with axi4-lite registers
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
module cci_top
  import cci_pkg::*;
#(
  parameter int WD_SLOW = WD_SLOW_CYC,
  parameter int WD_FAST = WD_FAST_CYC
)
(
  // clock and reset
  input  wire logic                  i_core_clk,
  input  wire logic                  i_srst,
  // axi4-lite slave
  input  wire logic [7:0]            i_awaddr,
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  output logic [1:0]                 o_bresp,
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  input  wire logic [7:0]            i_araddr,
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  output logic [31:0]                o_rdata,
  output logic [1:0]                 o_rresp,
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  // control channel side
  input  wire logic                  i_seq_err,
  input  wire logic                  i_link_lock,
  input  wire logic [6:0]            i_ser_id,
  input  wire cci_pkg::cci_rmt_req_t i_rmt_req,
  output cci_pkg::cci_rmt_rsp_t      o_rmt_rsp,
  // local i2c transactions and remap
  input  wire logic [6:0]            i_alias_match_0,
  input  wire cci_pkg::cci_txn_t     i_txn,
  output cci_pkg::cci_txn_t          o_fwd,
  // i2c pins
  input  wire logic                  i_sda_low_req,
  input  wire logic                  i_scl_i,
  output logic                       o_scl_o,
  output logic                       o_scl_oe,
  input  wire logic                  i_sda_i,
  output logic                       o_sda_o,
  output logic                       o_sda_oe,
  // interrupt
  output logic                       o_irq
);

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic known(input logic [5:0] idx);
    known = idx inside {IDX_CTRL2, IDX_SER, IDX_MAP0, IDX_IRQ_ST, IDX_IRQ_EN, IDX_IRQ_CL};
  endfunction : known

  function automatic logic [5:0] index_of(input logic [7:0] a);
    index_of = a[7:2];
  endfunction : index_of

  // ----------------------------------------
  // state
  // ----------------------------------------
  logic              aw_ok, w_ok, next_aw_ok, next_w_ok;
  logic [5:0]        aw_idx, next_aw_idx;
  logic [7:0]        w_byte, next_w_byte;
  logic              w_lane, next_w_lane;
  logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [31:0]       next_rdata;

  logic              seq_err, clear_bit, wr_block, wd_fast, wd_dis, hold, map0_lsb, lock_q;
  logic [1:0]        sda_dly;
  logic [6:0]        ser_addr, phys0;
  logic [IRQ_W-1:0]  irq_st, irq_en;
  logic              next_seq_err, next_clear_bit, next_wr_block, next_wd_fast, next_wd_dis;
  logic              next_hold, next_map0_lsb, next_irq;
  logic [1:0]        next_sda_dly;
  logic [6:0]        next_ser_addr, next_phys0;
  logic [IRQ_W-1:0]  next_irq_st, next_irq_en, irq_clr, events;
  cci_rmt_rsp_t      next_rmt_rsp;
  cci_txn_t          next_fwd;

  logic              wr_en, axi_wr, rmt_take, seq_clr, wd_free, wd_hung;
  logic [5:0]        wr_idx;
  logic [7:0]        wr_data, rd_byte;

  // ----------------------------------------
  // bus handshake and register reads
  // ----------------------------------------
  always_comb
  begin
    next_aw_ok   = aw_ok;
    next_aw_idx  = aw_idx;
    next_w_ok    = w_ok;
    next_w_byte  = w_byte;
    next_w_lane  = w_lane;
    next_bvalid  = o_bvalid;
    next_bresp   = o_bresp;
    next_arready = 1'b0;
    next_rvalid  = o_rvalid;
    next_rresp   = o_rresp;
    next_rdata   = o_rdata;
    rd_byte      = RST_BYTE;
    if (i_awvalid && o_awready)
    begin
      next_aw_ok  = 1'b1;
      next_aw_idx = index_of(i_awaddr);
    end
    if (i_wvalid && o_wready)
    begin
      next_w_ok   = 1'b1;
      next_w_byte = i_wdata[7:0];
      next_w_lane = i_wstrb[0];
    end
    if (o_bvalid && i_bready)
      next_bvalid = 1'b0;
    // both halves held: commit in one cycle, then answer
    axi_wr = aw_ok && w_ok && !o_bvalid;
    if (axi_wr)
    begin
      next_aw_ok  = 1'b0;
      next_w_ok   = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = known(aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    next_awready = !next_aw_ok && !next_bvalid;
    next_wready  = !next_w_ok && !next_bvalid;
    if (o_rvalid && i_rready)
      next_rvalid = 1'b0;
    if (i_arvalid && !o_rvalid && !o_arready)
    begin
      case (index_of(i_araddr))
        IDX_CTRL2:
          rd_byte = {seq_err, clear_bit, 1'b0, sda_dly, wr_block, wd_fast, wd_dis};
        IDX_SER:    rd_byte = {ser_addr, hold};
        IDX_MAP0:   rd_byte = {phys0, map0_lsb};
        IDX_IRQ_ST: rd_byte = {{(8 - IRQ_W){1'b0}}, irq_st};
        IDX_IRQ_EN: rd_byte = {{(8 - IRQ_W){1'b0}}, irq_en};
        default:    rd_byte = RST_BYTE;
      endcase
      next_arready = 1'b1;
      next_rvalid  = 1'b1;
      next_rdata   = {24'h000000, rd_byte};
      next_rresp   = known(index_of(i_araddr)) ? RESP_OKAY : RESP_SLVERR;
    end
    if (i_srst)
    begin
      next_aw_ok   = 1'b0;
      next_w_ok    = 1'b0;
      next_aw_idx  = '0;
      next_w_byte  = RST_BYTE;
      next_w_lane  = 1'b0;
      next_bvalid  = 1'b0;
      next_bresp   = RESP_OKAY;
      next_arready = 1'b0;
      next_rvalid  = 1'b0;
      next_rresp   = RESP_OKAY;
      next_rdata   = '0;
      next_awready = 1'b0;
      next_wready  = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    aw_ok     <= next_aw_ok;
    aw_idx    <= next_aw_idx;
    w_ok      <= next_w_ok;
    w_byte    <= next_w_byte;
    w_lane    <= next_w_lane;
    o_awready <= next_awready;
    o_wready  <= next_wready;
    o_bvalid  <= next_bvalid;
    o_bresp   <= next_bresp;
    o_arready <= next_arready;
    o_rvalid  <= next_rvalid;
    o_rresp   <= next_rresp;
    o_rdata   <= next_rdata;
  end

  // ----------------------------------------
  // configuration, status and remote access
  // ----------------------------------------
  always_comb
  begin
    next_seq_err   = seq_err;
    next_clear_bit = clear_bit;
    next_sda_dly   = sda_dly;
    next_wr_block  = wr_block;
    next_wd_fast   = wd_fast;
    next_wd_dis    = wd_dis;
    next_ser_addr  = ser_addr;
    next_hold      = hold;
    next_phys0     = phys0;
    next_map0_lsb  = map0_lsb;
    next_irq_en    = irq_en;
    next_rmt_rsp   = '0;
    irq_clr        = '0;
    seq_clr        = 1'b0;
    // software has the port first; a waiting remote request is taken next cycle
    rmt_take = i_rmt_req.valid && !o_rmt_rsp.done && !axi_wr;
    wr_en    = axi_wr && w_lane;
    wr_idx   = aw_idx;
    wr_data  = w_byte;
    if (rmt_take)
    begin
      next_rmt_rsp.done = 1'b1;
      if (!i_rmt_req.to_local_reg)
        next_rmt_rsp.passed = 1'b1;
      else if (wr_block)
        next_rmt_rsp.rejected = 1'b1;
      else
      begin
        wr_en   = 1'b1;
        wr_idx  = i_rmt_req.idx;
        wr_data = i_rmt_req.data;
      end
    end
    // auto-load on lock edge; a write in the same cycle overrides it
    if (i_link_lock && !lock_q && !hold)
      next_ser_addr = i_ser_id;
    if (wr_en)
    begin
      case (wr_idx)
        IDX_CTRL2:
        begin
          next_clear_bit = wr_data[BIT_SEQ_CLR];
          seq_clr        = wr_data[BIT_SEQ_CLR];
          next_sda_dly   = wr_data[DLY_HI:DLY_LO];
          next_wr_block  = wr_data[BIT_WR_BLOCK];
          next_wd_fast   = wr_data[BIT_WD_FAST];
          next_wd_dis    = wr_data[BIT_WD_DIS];
        end
        IDX_SER:
        begin
          next_ser_addr = wr_data[ADDR_HI:ADDR_LO];
          next_hold     = wr_data[BIT_HOLD];
        end
        IDX_MAP0:
        begin
          next_phys0    = wr_data[ADDR_HI:ADDR_LO];
          next_map0_lsb = wr_data[BIT_HOLD];
        end
        IDX_IRQ_EN: next_irq_en = wr_data[IRQ_W-1:0];
        IDX_IRQ_CL: irq_clr     = wr_data[IRQ_W-1:0];
        default:    irq_clr     = '0;
      endcase
    end
    // new events win over a clear in the same cycle
    next_seq_err = (seq_err && !seq_clr) || i_seq_err;
    events       = '0;
    events[IRQ_SEQ_ERR] = i_seq_err;
    events[IRQ_FREE]    = wd_free;
    events[IRQ_HUNG]    = wd_hung;
    events[IRQ_REJECT]  = next_rmt_rsp.rejected;
    next_irq_st  = (irq_st & ~irq_clr) | events;
    next_irq     = |(next_irq_st & next_irq_en);
    // remap: alias slot 0 first, then the serializer itself
    next_fwd = '0;
    if (i_txn.valid)
    begin
      if (i_alias_match_0 != ADDR_NONE && i_txn.addr == i_alias_match_0)
        next_fwd = '{valid: 1'b1, addr: phys0};
      else if (ser_addr != ADDR_NONE && i_txn.addr == ser_addr)
        next_fwd = '{valid: 1'b1, addr: ser_addr};
    end
    if (i_srst)
    begin
      next_seq_err   = 1'b0;
      next_clear_bit = 1'b0;
      next_sda_dly   = '0;
      next_wr_block  = 1'b0;
      next_wd_fast   = 1'b0;
      next_wd_dis    = 1'b0;
      next_ser_addr  = ADDR_NONE;
      next_hold      = 1'b0;
      next_phys0     = ADDR_NONE;
      next_map0_lsb  = 1'b0;
      next_irq_st    = '0;
      next_irq_en    = '0;
      next_irq       = 1'b0;
      next_rmt_rsp   = '0;
      next_fwd       = '0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    seq_err   <= next_seq_err;
    clear_bit <= next_clear_bit;
    sda_dly   <= next_sda_dly;
    wr_block  <= next_wr_block;
    wd_fast   <= next_wd_fast;
    wd_dis    <= next_wd_dis;
    ser_addr  <= next_ser_addr;
    hold      <= next_hold;
    phys0     <= next_phys0;
    map0_lsb  <= next_map0_lsb;
    irq_st    <= next_irq_st;
    irq_en    <= next_irq_en;
    o_irq     <= next_irq;
    o_rmt_rsp <= next_rmt_rsp;
    o_fwd     <= next_fwd;
    lock_q    <= i_srst ? 1'b0 : i_link_lock;
    o_scl_o   <= 1'b0;
    o_sda_o   <= 1'b0;
  end

  // ----------------------------------------
  // pin helpers
  // ----------------------------------------
  // open-drain pins only ever drive low, so the data flops stay at zero
  cci_sda_delay u_sda_delay
  (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_sel      (sda_dly),
    .i_sda_low  (i_sda_low_req),
    .o_sda_low  (o_sda_oe)
  );

  cci_bus_watchdog #(
    .SLOW_CYC (WD_SLOW),
    .FAST_CYC (WD_FAST)
  ) u_watchdog
  (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_disable  (wd_dis),
    .i_fast     (wd_fast),
    .i_scl      (i_scl_i),
    .i_sda      (i_sda_i),
    .o_scl_low  (o_scl_oe),
    .o_free     (wd_free),
    .o_hung     (wd_hung)
  );

endmodule : cci_top

// ### core/cci_pkg.sv
// package: constants, register map and carriers of the control channel i2c settings block
package cci_pkg;

  // ----------------------------------------
  // register indices (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [5:0] IDX_CTRL2  = 6'h06;
  localparam logic [5:0] IDX_SER    = 6'h07;
  localparam logic [5:0] IDX_MAP0   = 6'h08;
  localparam logic [5:0] IDX_IRQ_ST = 6'h10;
  localparam logic [5:0] IDX_IRQ_EN = 6'h11;
  localparam logic [5:0] IDX_IRQ_CL = 6'h12;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int         BIT_SEQ_ERR  = 7;
  localparam int         BIT_SEQ_CLR  = 6;
  localparam int         DLY_HI       = 4;
  localparam int         DLY_LO       = 3;
  localparam int         BIT_WR_BLOCK = 2;
  localparam int         BIT_WD_FAST  = 1;
  localparam int         BIT_WD_DIS   = 0;
  localparam int         ADDR_HI      = 7;
  localparam int         ADDR_LO      = 1;
  localparam int         BIT_HOLD     = 0;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [6:0] ADDR_NONE    = 7'h00;

  // interrupt status layout
  localparam int IRQ_W       = 4;
  localparam int IRQ_SEQ_ERR = 0;
  localparam int IRQ_FREE    = 1;
  localparam int IRQ_HUNG    = 2;
  localparam int IRQ_REJECT  = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ        = 100;
  localparam int CLK_PERIOD_NS  = 10;
  localparam int WD_SLOW_SEC    = 1;
  localparam int WD_FAST_US     = 50;
  localparam int WD_SLOW_CYC    = WD_SLOW_SEC * CLK_MHZ * 1000000;
  localparam int WD_FAST_CYC    = WD_FAST_US * CLK_MHZ;
  localparam int RCV_HALF_US    = 5;
  localparam int RCV_HALF_CYC   = RCV_HALF_US * CLK_MHZ;
  localparam int RCV_PULSES     = 9;
  localparam int SDA_BASE_NS    = 250;
  localparam int SDA_STEP_NS    = 50;
  localparam int SDA_DLY_MAX    = (SDA_BASE_NS + 3 * SDA_STEP_NS) / CLK_PERIOD_NS;
  localparam int WD_CNT_W       = 27;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic       valid;
    logic       to_local_reg;
    logic [5:0] idx;
    logic [7:0] data;
  } cci_rmt_req_t;

  typedef struct packed {
    logic done;
    logic rejected;
    logic passed;
  } cci_rmt_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [6:0] addr;
  } cci_txn_t;

endpackage : cci_pkg

// ### core/cci_sda_delay.sv
// selectable SDA output delay line
`timescale 1ns/10ps
module cci_sda_delay
  import cci_pkg::*;
(
  // clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_srst,
  // delay select and data
  input  wire logic [1:0] i_sel,
  input  wire logic       i_sda_low,
  output logic            o_sda_low
);

  // ----------------------------------------
  // tap arithmetic
  // ----------------------------------------
  // in -> sr[0] takes one edge, output flop one more
  function automatic int tap_of(input logic [1:0] code);
    tap_of = (SDA_BASE_NS + int'(code) * SDA_STEP_NS) / CLK_PERIOD_NS - 2;
  endfunction : tap_of

  logic [SDA_DLY_MAX-1:0] sr;
  logic [SDA_DLY_MAX-1:0] next_sr;
  logic                   next_out;

  always_comb
  begin
    next_sr  = {sr[SDA_DLY_MAX-2:0], i_sda_low};
    next_out = sr[tap_of(i_sel)];
    if (i_srst)
    begin
      next_sr  = '0;
      next_out = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    sr        <= next_sr;
    o_sda_low <= next_out;
  end

endmodule : cci_sda_delay

// ### core/cci_bus_watchdog.sv
// i2c bus watchdog with free detection and nine-pulse hung recovery
`timescale 1ns/10ps
module cci_bus_watchdog
  import cci_pkg::*;
#(
  parameter int SLOW_CYC = WD_SLOW_CYC,
  parameter int FAST_CYC = WD_FAST_CYC
)
(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_srst,
  // control
  input  wire logic i_disable,
  input  wire logic i_fast,
  // bus levels
  input  wire logic i_scl,
  input  wire logic i_sda,
  // results
  output logic      o_scl_low,
  output logic      o_free,
  output logic      o_hung
);

  typedef enum logic [1:0] {WATCH, PULSE_LOW, PULSE_HIGH} cci_wd_st_t;

  cci_wd_st_t          st, next_st;
  logic [WD_CNT_W-1:0] cnt, next_cnt;
  logic [3:0]          pulses, next_pulses;
  logic                fired, next_fired;
  logic                scl_q, sda_q;
  logic                next_scl_low, next_free, next_hung;
  logic [WD_CNT_W-1:0] limit;
  logic                quiet;

  always_comb
  begin
    limit        = i_fast ? WD_CNT_W'(FAST_CYC - 1) : WD_CNT_W'(SLOW_CYC - 1);
    quiet        = (i_scl == scl_q) && (i_sda == sda_q);
    next_st      = st;
    next_cnt     = cnt + 1'b1;
    next_pulses  = pulses;
    next_fired   = fired;
    next_scl_low = o_scl_low;
    next_free    = 1'b0;
    next_hung    = 1'b0;
    case (st)
      WATCH:
      begin
        if (i_disable || !quiet)
        begin
          next_cnt   = '0;
          next_fired = 1'b0;
        end
        else if (cnt == limit && !fired)
        begin
          next_cnt   = '0;
          next_fired = 1'b1;
          if (i_sda)
            next_free = 1'b1;
          else
          begin
            next_st      = PULSE_LOW;
            next_pulses  = '0;
            next_scl_low = 1'b1;
          end
        end
        else if (fired)
          next_cnt = cnt;
      end
      PULSE_LOW:
        if (cnt == WD_CNT_W'(RCV_HALF_CYC - 1))
        begin
          next_cnt     = '0;
          next_scl_low = 1'b0;
          next_st      = PULSE_HIGH;
        end
      PULSE_HIGH:
        if (cnt == WD_CNT_W'(RCV_HALF_CYC - 1))
        begin
          next_cnt    = '0;
          next_pulses = pulses + 1'b1;
          if (pulses == 4'(RCV_PULSES - 1))
          begin
            next_st   = WATCH;
            next_hung = 1'b1;
          end
          else
          begin
            next_st      = PULSE_LOW;
            next_scl_low = 1'b1;
          end
        end
      default:
        next_st = WATCH;
    endcase
    if (i_srst)
    begin
      next_st      = WATCH;
      next_cnt     = '0;
      next_pulses  = '0;
      next_fired   = 1'b0;
      next_scl_low = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk)
  begin
    st        <= next_st;
    cnt       <= next_cnt;
    pulses    <= next_pulses;
    fired     <= next_fired;
    scl_q     <= i_scl;
    sda_q     <= i_sda;
    o_scl_low <= next_scl_low;
    o_free    <= next_free;
    o_hung    <= next_hung;
  end

endmodule : cci_bus_watchdog

// ### tb/cci_top_asserts.sv
// assertion checker for the control channel i2c block
`timescale 1ns/10ps
module cci_top_asserts
  import cci_pkg::*;
(
  // clock and reset
  input wire logic                  i_core_clk,
  input wire logic                  i_srst,
  // watched ports
  input wire logic                  i_bready,
  input wire logic                  i_rready,
  input wire logic                  o_bvalid,
  input wire logic [1:0]            o_bresp,
  input wire logic                  o_rvalid,
  input wire logic [31:0]           o_rdata,
  input wire cci_pkg::cci_rmt_req_t i_rmt_req,
  input wire cci_pkg::cci_rmt_rsp_t o_rmt_rsp,
  input wire logic [6:0]            i_alias_match_0,
  input wire cci_pkg::cci_txn_t     i_txn,
  input wire cci_pkg::cci_txn_t     o_fwd,
  input wire logic                  i_sda_low_req,
  input wire logic                  o_sda_oe,
  input wire logic                  o_scl_oe,
  input wire logic                  o_scl_o,
  input wire logic                  o_sda_o,
  input wire logic                  o_irq
);
  // cycles since the delay request last changed, saturating
  logic [7:0] dly_cnt;
  logic       last_req;
  always_ff @(posedge i_core_clk)
  begin
    last_req <= i_sda_low_req;
    if (i_srst || i_sda_low_req != last_req)
      dly_cnt <= 8'h00;
    else if (dly_cnt != 8'hff)
      dly_cnt <= dly_cnt + 8'h01;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  AST_BHOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  AST_RHOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  AST_REJ: assert property (o_rmt_rsp.rejected |->
    o_rmt_rsp.done && $past(i_rmt_req.to_local_reg)) else $error("bad remote reject");
  AST_PASS: assert property (o_rmt_rsp.done && !$past(i_rmt_req.to_local_reg) |->
    o_rmt_rsp.passed && !o_rmt_rsp.rejected) else $error("remote pass blocked");
  AST_FWD: assert property (i_txn.valid && i_alias_match_0 != 7'h00 &&
    i_txn.addr == i_alias_match_0 |=> o_fwd.valid) else $error("alias not forwarded");
  AST_NOFWD: assert property (!i_txn.valid |=> !o_fwd.valid)
    else $error("forward without transaction");
  AST_PIN: assert property (!o_scl_o && !o_sda_o)
    else $error("open drain pin driven high");
  AST_PULSE: assert property ($rose(o_scl_oe) |-> o_scl_oe [*8])
    else $error("recovery pulse too short");
  AST_SDLY: assert property ($changed(o_sda_oe) |->
    dly_cnt >= 8'h16 && dly_cnt <= 8'h2a) else $error("sda delay out of range");
  AST_RST: assert property (disable iff (1'h0) i_srst |=>
    !o_bvalid && !o_rvalid && !o_irq && !o_scl_oe) else $error("outputs busy in reset");
endmodule : cci_top_asserts

bind cci_top cci_top_asserts cci_top_asserts_i (
  .i_core_clk, .i_srst, .i_bready, .i_rready, .o_bvalid, .o_bresp, .o_rvalid, .o_rdata,
  .i_rmt_req, .o_rmt_rsp, .i_alias_match_0, .i_txn, .o_fwd, .i_sda_low_req, .o_sda_oe,
  .o_scl_oe, .o_scl_o, .o_sda_o, .o_irq);

// ### tb/cci_partner.sv
// far-side model: serializer feeding the control channel
`timescale 1ns/10ps
module cci_partner
  import cci_pkg::*;
(
  // clock
  input  wire logic                  i_clk,
  // control channel
  input  wire cci_pkg::cci_rmt_rsp_t i_rsp,
  output cci_pkg::cci_rmt_req_t      o_req,
  output logic                       o_seq_err,
  output logic                       o_lock,
  output logic [6:0]                 o_id
);
  initial {o_req, o_seq_err, o_lock, o_id} = {18'h0, 7'h7f};
  task automatic send(input logic tl, input logic [5:0] idx, input logic [7:0] d,
    output cci_rmt_rsp_t r);
    @(posedge i_clk);
    o_req <= '{1'h1, tl, idx, d};
    do
      @(negedge i_clk);
    while (!i_rsp.done);
    r = i_rsp;
    @(posedge i_clk);
    // released lines show the inverse so stale data never looks valid
    o_req <= '{1'h0, ~tl, ~idx, ~d};
  endtask : send
  task automatic err;
    @(posedge i_clk);
    o_seq_err <= 1'h1;
    @(posedge i_clk);
    o_seq_err <= 1'h0;
  endtask : err
  task automatic lock(input logic [6:0] id);
    @(posedge i_clk);
    o_lock <= 1'h0;
    @(posedge i_clk);
    {o_lock, o_id} <= {1'h1, id};
    repeat (2) @(posedge i_clk);
    o_id <= ~id;
  endtask : lock
endmodule : cci_partner

// ### tb/cci_top_test.sv
// self-checking bench for the control channel i2c block
`timescale 1ns/10ps
module cci_top_test;
  import cci_pkg::*;
  logic         clk = 1'h0, srst = 1'h1, awv = 1'h0, wv = 1'h0, bready = 1'h0;
  logic         arv = 1'h0, rready = 1'h0, sda_req = 1'h0, sda_hold = 1'h0, p;
  logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]  wdata = 32'h0, rdata;
  logic         awr, wr_r, bv, arr, rv, irq, scl_o, scl_oe, sda_o, sda_oe, seq_err, lock;
  logic [1:0]   bresp, rresp;
  logic [6:0]   ser_id, alias0 = 7'h00;
  cci_txn_t     txn = '0, fwd;
  cci_rmt_req_t rreq;
  cci_rmt_rsp_t rrsp, r3;
  wire          scl = !scl_oe;
  wire          sda = !(sda_oe || sda_hold);
  int           n_mismatch = 0, samples_checked = 0, n;
  always #5 clk = ~clk;
  cci_top #(.WD_SLOW(200), .WD_FAST(50)) cci_top_i (
    .i_core_clk(clk), .i_srst(srst), .i_awaddr(awaddr), .i_awvalid(awv), .o_awready(awr),
    .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wv), .o_wready(wr_r), .o_bresp(bresp),
    .o_bvalid(bv), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arv), .o_arready(arr),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rv), .i_rready(rready),
    .i_seq_err(seq_err), .i_link_lock(lock), .i_ser_id(ser_id), .i_rmt_req(rreq),
    .o_rmt_rsp(rrsp), .i_alias_match_0(alias0), .i_txn(txn), .o_fwd(fwd),
    .i_sda_low_req(sda_req), .i_scl_i(scl), .o_scl_o(scl_o), .o_scl_oe(scl_oe),
    .i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_irq(irq));
  cci_partner cci_partner_i (.i_clk(clk), .i_rsp(rrsp), .o_req(rreq), .o_seq_err(seq_err),
    .o_lock(lock), .o_id(ser_id));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_mismatch++;
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw, sb;
    logic [1:0] br;
    @(posedge clk);
    {awaddr, wdata, awv, wv, bready} <= {a, d, 3'h7};
    do
    begin
      @(negedge clk);
      {ta, tw, sb, br} = {awr, wr_r, bv, bresp};
      @(posedge clk);
      if (ta) awv <= 1'h0;
      if (tw) wv <= 1'h0;
    end while (!sb);
    bready <= 1'h0;
    chk("bresp", er, br);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
    input logic [1:0] er);
    logic ta, sv;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    {araddr, arv, rready} <= {a, 2'h3};
    do
    begin
      @(negedge clk);
      {ta, sv, d, r} = {arr, rv, rdata, rresp};
      @(posedge clk);
      if (ta) arv <= 1'h0;
    end while (!sv);
    rready <= 1'h0;
    chk("rdata", {24'h0, e}, d & {24'hffffff, m});
    chk("rresp", er, r);
  endtask : rd
  task automatic send_txn(input logic [6:0] a, input logic v, input logic [6:0] e);
    @(posedge clk);
    txn <= '{1'h1, a};
    @(posedge clk);
    txn <= '{1'h0, ~a};
    @(negedge clk);
    chk("fwd", {v, e}, {fwd.valid, v ? fwd.addr : e});
  endtask : send_txn
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'h0;
    alias0 <= 7'h30;
    repeat (2) @(posedge clk);
    rd(8'h18, 8'hff, 8'h00, RESP_OKAY);
    rd(8'h1c, 8'hff, 8'h00, RESP_OKAY);
    rd(8'h20, 8'hff, 8'h00, RESP_OKAY);
    rd(8'h04, 8'hff, 8'h00, RESP_SLVERR);
    wr(8'h04, 32'h1, RESP_SLVERR);
    wr(8'h18, 32'ha0, RESP_OKAY);
    rd(8'h18, 8'hff, 8'h00, RESP_OKAY);
    $display("end of register test");
    cci_partner_i.err();
    rd(8'h18, 8'hff, 8'h80, RESP_OKAY);
    repeat (20) @(posedge clk);
    rd(8'h18, 8'hff, 8'h80, RESP_OKAY);
    wr(8'h44, 32'h1, RESP_OKAY);
    chk("irq", 1, irq);
    wr(8'h18, 32'h40, RESP_OKAY);
    rd(8'h18, 8'hff, 8'h40, RESP_OKAY);
    wr(8'h48, 32'h1, RESP_OKAY);
    rd(8'h40, 8'h01, 8'h00, RESP_OKAY);
    chk("irq", 0, irq);
    wr(8'h44, 32'h0, RESP_OKAY);
    cci_partner_i.err();
    rd(8'h40, 8'h01, 8'h01, RESP_OKAY);
    chk("irq", 0, irq);
    wr(8'h48, 32'h1, RESP_OKAY);
    $display("end of sequence error test");
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h18, 32'(c << 3), RESP_OKAY);
      sda_req <= 1'h1;
      for (n = 0; !sda_oe && n < 60; n++)
        @(negedge clk);
      chk("sda_dly", 1, 32'(n >= 25 + 5 * c && n <= 27 + 5 * c));
      @(posedge clk);
      sda_req <= 1'h0;
      repeat (45) @(posedge clk);
    end
    $display("end of sda delay test");
    cci_partner_i.send(1'h1, IDX_MAP0, 8'h22, r3);
    chk("rmt", 3'h4, r3);
    rd(8'h20, 8'hff, 8'h22, RESP_OKAY);
    wr(8'h18, 32'h04, RESP_OKAY);
    cci_partner_i.send(1'h1, IDX_MAP0, 8'h44, r3);
    chk("rmt", 3'h6, r3);
    rd(8'h20, 8'hff, 8'h22, RESP_OKAY);
    rd(8'h40, 8'h08, 8'h08, RESP_OKAY);
    cci_partner_i.send(1'h0, IDX_MAP0, 8'h55, r3);
    chk("rmt", 3'h5, r3);
    wr(8'h18, 32'h00, RESP_OKAY);
    $display("end of remote test");
    cci_partner_i.lock(7'h2a);
    rd(8'h1c, 8'hff, 8'h54, RESP_OKAY);
    send_txn(7'h2a, 1'h1, 7'h2a);
    send_txn(7'h30, 1'h1, 7'h11);
    send_txn(7'h31, 1'h0, 7'h31);
    wr(8'h1c, 32'h2b, RESP_OKAY);
    cci_partner_i.lock(7'h2c);
    rd(8'h1c, 8'hff, 8'h2b, RESP_OKAY);
    wr(8'h1c, 32'h01, RESP_OKAY);
    send_txn(7'h15, 1'h0, 7'h15);
    $display("end of address test");
    for (int s = 0; s < 3; s++)
    begin
      wr(8'h18, s == 1 ? 32'h0 : 32'h2 + s / 2, RESP_OKAY);
      wr(8'h48, 32'hf, RESP_OKAY);
      sda_hold <= 1'h1;
      @(posedge clk);
      sda_hold <= 1'h0;
      repeat (s ? 120 : 30) @(posedge clk);
      rd(8'h40, 8'h02, 8'h00, RESP_OKAY);
      repeat (s ? 120 : 40) @(posedge clk);
      rd(8'h40, 8'h06, s < 2 ? 8'h02 : 8'h00, RESP_OKAY);
    end
    wr(8'h18, 32'h2, RESP_OKAY);
    wr(8'h48, 32'hf, RESP_OKAY);
    sda_hold <= 1'h1;
    n = 0;
    p = 1'h0;
    repeat (9300)
    begin
      @(negedge clk);
      if (scl_oe && !p) n++;
      p = scl_oe;
    end
    chk("pulses", 9, n);
    sda_hold <= 1'h0;
    rd(8'h40, 8'h04, 8'h04, RESP_OKAY);
    $display("end of watchdog test");
    finish_test();
  end
  initial
  begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    finish_test();
  end
endmodule : cci_top_test
